// file: verilog/gst_pkg.sv
// constants and types shared by the gated sixteen-bit timer core
package gst_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ  = 40_000_000;
  localparam int unsigned INSTR_DIV    = 4;
  localparam logic [1:0]  INSTR_LAST   = 2'(INSTR_DIV - 1);

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W       = 3;
  localparam logic [2:0]  ADDR_CNT_LO  = 3'h0;
  localparam logic [2:0]  ADDR_CNT_HI  = 3'h1;
  localparam logic [2:0]  ADDR_CTRL    = 3'h2;
  localparam logic [2:0]  ADDR_GCTRL   = 3'h3;
  localparam logic [2:0]  ADDR_STAT    = 3'h4;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_RUN     = 0;
  localparam int unsigned CTRL_ASYNC   = 1;
  localparam int unsigned CTRL_DIV_LSB = 2;
  localparam int unsigned CTRL_SRC_LSB = 4;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  CTRL_MASK    = 8'h3F;

  // ---------------------------------------------------------------
  // gate control register fields
  // ---------------------------------------------------------------
  localparam int unsigned GCTRL_EN     = 7;
  localparam int unsigned GCTRL_POL    = 6;
  localparam int unsigned GCTRL_TGL    = 5;
  localparam int unsigned GCTRL_SPM    = 4;
  localparam int unsigned GCTRL_GO     = 3;
  localparam int unsigned GCTRL_GATE_LEVEL_VALUE   = 2;
  localparam logic [7:0]  GCTRL_RST    = 8'h00;
  localparam logic [7:0]  GCTRL_WMASK  = 8'hF8;

  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int unsigned STAT_ROLL    = 0;

  // ---------------------------------------------------------------
  // count source encoding
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    GST_SRC_INSTR,
    GST_SRC_FOSC,
    GST_SRC_EXT,
    GST_SRC_NONE
  } gst_src_t;

endpackage

// file: verilog/gst_edge_if.sv
// level and edge events of one synchronised pin
`timescale 1ns/1ps
interface gst_edge_if;
  logic level;
  logic rise;
  logic fall;

  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface // gst_edge_if

// file: verilog/gst_edge_sync.sv
// pin synchroniser with agreement filter and edge detection
`timescale 1ns/1ps
module gst_edge_sync #(
  parameter int unsigned STAGES = 3
) (
  // clock and control
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  // pin
  input  wire logic i_pin,
  // events
  gst_edge_if.src   o_ev
);

  if (STAGES < 3) begin : g_stage_chk
    $error("gst_edge_sync needs at least three stages");
  end

  // ---------------------------------------------------------------
  // shift chain and filtered level
  // ---------------------------------------------------------------
  logic [STAGES-1:0] sync_q;
  logic              level_q;
  logic              rise_q;
  logic              fall_q;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync_q <= '0;
    end else if (i_ce) begin
      sync_q <= {sync_q[STAGES-2:0], i_pin};
    end
  end

  // change taken once the last two stages agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end else if (i_ce) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (sync_q[STAGES-1] == sync_q[STAGES-2] && sync_q[STAGES-1] != level_q) begin
        level_q <= sync_q[STAGES-1];
        rise_q  <= sync_q[STAGES-1];
        fall_q  <= ~sync_q[STAGES-1];
      end
    end
  end

  assign o_ev.level = level_q;
  assign o_ev.rise  = rise_q & i_ce;
  assign o_ev.fall  = fall_q & i_ce;

endmodule // gst_edge_sync

// file: verilog/gst_timer_top.sv
// gated sixteen-bit timer core with byte-wide register port
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module gst_timer_top #(
  parameter int unsigned CNT_W = 16
) (
  // clock, reset, enable
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_ce,
  // register port
  input  wire logic [gst_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  // pins and system
  input  wire logic                      i_ext_count,
  input  wire logic                      i_gate,
  input  wire logic                      i_sleep,
  // status
  output logic      [CNT_W-1:0]          o_count,
  output logic                           o_rollover_flag,
  output logic                           o_wake
);

  if (CNT_W != 16) begin : g_width_chk
    $error("gst_timer_top supports a sixteen-bit counter only");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    div_limit = 3'((4'h1 << sel) - 4'h1);
  endfunction

  function automatic logic is_wr(input logic wr, input logic [2:0] a, input logic [2:0] t);
    is_wr = wr && (a == t);
  endfunction

  // ---------------------------------------------------------------
  // pin front ends
  // ---------------------------------------------------------------
  gst_edge_if ext_ev ();
  gst_edge_if gate_ev ();

  gst_edge_sync #(.STAGES(3)) u_ext_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_pin      (i_ext_count),
    .o_ev       (ext_ev.src)
  );

  gst_edge_sync #(.STAGES(3)) u_gate_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_pin      (i_gate),
    .o_ev       (gate_ev.src)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]       ctrl_q;
  logic [7:0]       gctrl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0]       presc_q;
  logic [1:0]       phase_q;
  logic             armed_q;
  logic             pend_q;
  logic             roll_q;
  logic             wake_q;
  logic [7:0]       rdata_q;

  logic             run;
  logic             async_mode;
  logic [1:0]       div_sel;
  gst_pkg::gst_src_t src;
  logic             gate_en;
  logic             gate_pol;
  logic             gate_val;
  logic             instr_tick;
  logic             cnt_wr;
  logic             src_step;
  logic             awake;
  logic             gate_ok;
  logic             step;
  logic             inc;
  logic             ext_async;

  assign run        = ctrl_q[gst_pkg::CTRL_RUN];
  assign async_mode = ctrl_q[gst_pkg::CTRL_ASYNC];
  assign div_sel    = ctrl_q[gst_pkg::CTRL_DIV_LSB +: 2];
  assign src        = gst_pkg::gst_src_t'(ctrl_q[gst_pkg::CTRL_SRC_LSB +: 2]);
  assign gate_en    = gctrl_q[gst_pkg::GCTRL_EN];
  assign gate_pol   = gctrl_q[gst_pkg::GCTRL_POL];
  assign instr_tick = (phase_q == gst_pkg::INSTR_LAST);
  assign cnt_wr     = is_wr(i_wr, i_addr, gst_pkg::ADDR_CNT_LO)
                    | is_wr(i_wr, i_addr, gst_pkg::ADDR_CNT_HI);
  assign ext_async  = async_mode && (src == gst_pkg::GST_SRC_EXT);

  // ---------------------------------------------------------------
  // instruction cycle phase
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      phase_q <= 2'h0;
    end else if (i_ce) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // control and gate registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_q <= gst_pkg::CTRL_RST;
    end else if (i_ce && is_wr(i_wr, i_addr, gst_pkg::ADDR_CTRL)) begin
      ctrl_q <= i_wdata & gst_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gctrl_q <= gst_pkg::GCTRL_RST;
    end else if (i_ce && is_wr(i_wr, i_addr, gst_pkg::ADDR_GCTRL)) begin
      gctrl_q <= i_wdata & gst_pkg::GCTRL_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // edge arming and synchronous alignment
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (i_ce) begin
      if (!run || cnt_wr) begin
        armed_q <= 1'b0;
      end else if (ext_ev.fall) begin
        armed_q <= 1'b1;
      end
    end
  end

  // edge held until the next instruction boundary in synchronous mode
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend_q <= 1'b0;
    end else if (i_ce) begin
      if (async_mode || cnt_wr || !run) begin
        pend_q <= 1'b0;
      end else if (ext_ev.rise && armed_q) begin
        pend_q <= 1'b1;
      end else if (instr_tick) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // step qualification
  // ---------------------------------------------------------------
  always_comb begin
    unique case (src)
      gst_pkg::GST_SRC_INSTR: src_step = instr_tick;
      gst_pkg::GST_SRC_FOSC:  src_step = 1'b1;
      gst_pkg::GST_SRC_EXT:   src_step = async_mode ? (ext_ev.rise && armed_q)
                                                    : (pend_q && instr_tick);
      default:                src_step = 1'b0;
    endcase
  end

  assign gate_val = (gate_ev.level == gate_pol);
  assign gate_ok  = !gate_en || gate_val;
  assign awake    = !i_sleep || ext_async;
  assign step     = i_ce && run && gate_ok && awake && src_step && !cnt_wr;
  assign inc      = step && (presc_q == div_limit(div_sel));

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      presc_q <= 3'h0;
    end else if (i_ce) begin
      if (cnt_wr || (is_wr(i_wr, i_addr, gst_pkg::ADDR_CTRL)
                     && i_wdata[gst_pkg::CTRL_DIV_LSB +: 2] != div_sel)) begin
        presc_q <= 3'h0;
      end else if (inc) begin
        presc_q <= 3'h0;
      end else if (step) begin
        presc_q <= presc_q + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      if (is_wr(i_wr, i_addr, gst_pkg::ADDR_CNT_LO)) begin
        cnt_q[7:0] <= i_wdata;
      end else if (is_wr(i_wr, i_addr, gst_pkg::ADDR_CNT_HI)) begin
        cnt_q[15:8] <= i_wdata;
      end else if (inc) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // rollover flag and wake
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      roll_q <= 1'b0;
    end else if (i_ce) begin
      if (inc && cnt_q == 16'hFFFF) begin
        roll_q <= 1'b1;
      end else if (is_wr(i_wr, i_addr, gst_pkg::ADDR_STAT)) begin
        roll_q <= i_wdata[gst_pkg::STAT_ROLL];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wake_q <= 1'b0;
    end else if (i_ce) begin
      wake_q <= inc && cnt_q == 16'hFFFF && i_sleep && ext_async;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (i_ce) begin
      rdata_q <= 8'h00;
      if (i_rd) begin
        unique case (i_addr)
          gst_pkg::ADDR_CNT_LO: rdata_q <= cnt_q[7:0];
          gst_pkg::ADDR_CNT_HI: rdata_q <= cnt_q[15:8];
          gst_pkg::ADDR_CTRL:   rdata_q <= ctrl_q;
          gst_pkg::ADDR_GCTRL:  rdata_q <= {gctrl_q[7:3], gate_val, 2'h0};
          gst_pkg::ADDR_STAT:   rdata_q <= {7'h00, roll_q};
          default:              rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign o_rdata         = rdata_q;
  assign o_count         = cnt_q;
  assign o_rollover_flag = roll_q;
  assign o_wake          = wake_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_write_lo;
    i_ce && is_wr(i_wr, i_addr, gst_pkg::ADDR_CNT_LO) |=> cnt_q[7:0] == $past(i_wdata);
  endproperty
  a_write_lo: assert property (p_write_lo) else $error("low byte write lost");

  property p_off_holds;
    !run && !cnt_wr |=> $stable(cnt_q);
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("counter moved while off");

  property p_gate_hold;
    run && gate_en && (gate_ev.level != gate_pol) && !cnt_wr |=> $stable(cnt_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("counted with gate closed");

  property p_fosc_rate;
    i_ce && run && !gate_en && !i_sleep && src == gst_pkg::GST_SRC_FOSC
      && div_sel == 2'h0 && !i_wr |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_fosc_rate: assert property (p_fosc_rate) else $error("full-rate step missing");

  property p_instr_rate;
    src == gst_pkg::GST_SRC_INSTR && !instr_tick && !cnt_wr |=> $stable(cnt_q);
  endproperty
  a_instr_rate: assert property (p_instr_rate) else $error("step off instruction tick");

  property p_arm_clear;
    i_ce && (cnt_wr || !run) |=> !armed_q;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("edge arm not cleared");

  property p_presc_clr;
    i_ce && cnt_wr |=> presc_q == 3'h0;
  endproperty
  a_presc_clr: assert property (p_presc_clr) else $error("prescaler not cleared");

  property p_presc_lim;
    presc_q <= div_limit(div_sel) || $changed(div_sel);
  endproperty
  a_presc_lim: assert property (p_presc_lim) else $error("prescaler past limit");

  property p_rollover;
    inc && cnt_q == 16'hFFFF |=> cnt_q == 16'h0000 && roll_q;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover not flagged");

  property p_sleep_hold;
    i_sleep && !ext_async && !cnt_wr |=> $stable(cnt_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");

  property p_wake_cause;
    o_wake |-> $past(ext_async) && $past(i_sleep) && roll_q;
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without cause");

  property p_read_lo;
    i_ce && i_rd && i_addr == gst_pkg::ADDR_CNT_LO |=> o_rdata == $past(cnt_q[7:0]);
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("low byte read wrong");

  property p_c_roll;
    inc && cnt_q == 16'hFFFF;
  endproperty
  c_roll: cover property (p_c_roll);

  property p_c_ext;
    src == gst_pkg::GST_SRC_EXT && inc;
  endproperty
  c_ext: cover property (p_c_ext);

  property p_c_wake;
    o_wake;
  endproperty
  c_wake: cover property (p_c_wake);

endmodule // gst_timer_top

// file: tb/gst_ext_src.sv
// external count source model driving the count pin
`timescale 1ns/1ps
module gst_ext_src (
  // clock
  input  wire logic       i_core_clk,
  // control from bench
  input  wire logic       i_set,
  input  wire logic       i_set_lvl,
  input  wire logic       i_start,
  input  wire logic [7:0] i_pulses,
  input  wire logic [3:0] i_half,
  // pin
  output logic            o_pin
);
  // ---------------------------------------------------------------
  // pulse train generator
  // ---------------------------------------------------------------
  logic [8:0] togs_q;
  logic [3:0] tick_q;

  always @(posedge i_core_clk) begin
    if (i_set) begin
      o_pin  <= i_set_lvl;
      togs_q <= 9'h000;
    end else if (i_start) begin
      togs_q <= {i_pulses, 1'b0};
      tick_q <= 4'h0;
    end else if (togs_q != 9'h000) begin
      if (tick_q == i_half - 4'h1) begin
        tick_q <= 4'h0;
        o_pin  <= ~o_pin;
        togs_q <= togs_q - 9'h001;
      end else begin
        tick_q <= tick_q + 4'h1;
      end
    end
  end
endmodule  // gst_ext_src

// file: tb/tb_top.sv
// self-checking bench for the gated sixteen-bit timer core
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, rst, wr, rd, ext, gate, sleep, p_set, p_lvl, p_go, roll, wake, pend;
  logic        ce;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, p_n;
  logic [15:0] count, v;
  logic [7:0]  exp_q[$];
  int          fail_count, n_tests, wake_cnt, seed;

  gst_timer_top gst_timer_top_i (.i_core_clk(core_clk), .i_rst(rst), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_ext_count(ext), .i_gate(gate), .i_sleep(sleep), .o_count(count),
    .o_rollover_flag(roll), .o_wake(wake));
  gst_ext_src gst_ext_src_i (.i_core_clk(core_clk), .i_set(p_set), .i_set_lvl(p_lvl),
    .i_start(p_go), .i_pulses(p_n), .i_half(4'h6), .o_pin(ext));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    rd <= 1'b1; addr <= a;
    exp_q.push_back(e);
    @(posedge core_clk);
    rd <= 1'b0;
  endtask

  task automatic pin(input logic l);
    @(posedge core_clk);
    p_set <= 1'b1; p_lvl <= l;
    @(posedge core_clk);
    p_set <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  // load, run for m+2 edges (m+4 when n pin pulses are sent), stop, read back
  task automatic run(input logic [7:0] c, input logic [15:0] s, input int m,
                     input logic [7:0] n, input logic [15:0] e);
    wr_reg(3'h0, s[7:0]);
    wr_reg(3'h1, s[15:8]);
    wr_reg(3'h2, c);
    if (n != 8'h00) begin
      @(posedge core_clk);
      p_go <= 1'b1; p_n <= n;
      @(posedge core_clk);
      p_go <= 1'b0;
    end
    repeat (m) @(posedge core_clk);
    wr_reg(3'h2, c & 8'hFE);
    rd_reg(3'h0, e[7:0]);
    rd_reg(3'h1, e[15:8]);
  endtask

  // ---------------------------------------------------------------
  // clock, monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (pend) begin
      chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
    pend <= rd;
    if (wake === 1'b1) begin
      wake_cnt++;
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 29544; rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 3'h0; wdata = 8'h00;
    gate = 1'b0; sleep = 1'b0; p_set = 1'b1; p_lvl = 1'b0; p_go = 1'b0; p_n = 8'h00;
    ce = 1'b1; fail_count = 0; n_tests = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0; p_set <= 1'b0;
    wr_reg(3'h7, 8'hA5);
    wr_reg(3'h5, 8'h5A);
    for (int a = 0; a < 8; a++) rd_reg(a[2:0], (a == 3) ? 8'h04 : 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      wr_reg(3'h0, v[7:0]);
      wr_reg(3'h1, v[15:8]);
      rd_reg(3'h0, v[7:0]);
      rd_reg(3'h1, v[15:8]);
      #1 chk(count, v);
    end
    ce <= 1'b0;
    wr_reg(3'h0, ~v[7:0]);
    ce <= 1'b1;
    #1 chk(count, v);
    for (int d = 0; d < 4; d++) run(8'h11 | 8'(d << 2), 16'h0000, 41, 8'h00, 16'(43 >> d));
    run(8'h01, 16'h0000, 38, 8'h00, 16'h000A);
    run(8'h31, 16'h0000, 38, 8'h00, 16'h0000);
    run(8'h10, 16'h0000, 38, 8'h00, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      for (int g = 0; g < 2; g++) begin
        gate <= g[0];
        repeat (8) @(posedge core_clk);
        wr_reg(3'h3, {1'b1, p[0], 6'h3F});
        rd_reg(3'h3, {1'b1, p[0], 3'h7, p == g, 2'h0});
        run(8'h11, 16'h0000, 38, 8'h00, (p == g) ? 16'h0028 : 16'h0000);
      end
    end
    wr_reg(3'h3, 8'h00);
    pin(1'b0);
    run(8'h23, 16'h0000, 80, 8'h05, 16'h0004);
    run(8'h21, 16'h0000, 80, 8'h05, 16'h0004);
    pin(1'b1);
    run(8'h23, 16'h0000, 80, 8'h05, 16'h0005);
    run(8'h11, 16'hFFF0, 38, 8'h00, 16'h0018);
    chk({15'h0000, roll}, 16'h0001);
    rd_reg(3'h4, 8'h01);
    wr_reg(3'h4, 8'h00);
    rd_reg(3'h4, 8'h00);
    chk(16'(wake_cnt), 16'h0000);
    sleep <= 1'b1;
    run(8'h23, 16'hFFFF, 44, 8'h01, 16'h0000);
    chk(16'(wake_cnt), 16'h0001);
    run(8'h21, 16'hFFFF, 44, 8'h01, 16'hFFFF);
    run(8'h11, 16'h0000, 38, 8'h00, 16'h0000);
    chk(16'(wake_cnt), 16'h0001);
    sleep <= 1'b0;
    repeat (4) @(posedge core_clk);
    end_sim;
  end
endmodule  // tb_top
